// [hdl/pin_direction_combiner.sv]
// AHB-Lite register block merging per-core pin direction registers
`timescale 1ns/1ps
`include "pin_direction_params.svh"
module pin_direction_combiner import pin_direction_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic [3:0] hprot,
  input wire logic hmastlock,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [`PD_PINS-1:0] pin_dir,
  output logic [`PD_CORES-1:0] core_active
);
  bus_phase_e state;
  bus_phase_e next_state;
  logic [11:0] addr_q;
  logic [31:0] combined;
  core_wr_s core_wr [`PD_CORES];
  core_rd_s core_rd [`PD_CORES];
  logic [31:0] core_dir [`PD_CORES];
  logic [`PD_CORES-1:0] core_en;

  // hsize, hburst, hprot and hmastlock carry nothing for single word accesses
  wire accept = hsel && htrans[1] && hready;
  wire in_core = addr_q[`PD_CORE_AREA_MSB:`PD_CORE_AREA_LSB] == 4'h0;
  wire [`PD_CORE_IDX_W-1:0] core_idx = addr_q[7:5];
  wire [4:0] reg_ofs = addr_q[4:0];
  wire wr_phase = state == PH_WRITE;

  always_comb begin
    next_state = PH_IDLE;
    case (state)
      PH_READ: next_state = PH_DONE;
      PH_IDLE, PH_WRITE, PH_DONE: begin
        if (accept) begin
          next_state = hwrite ? PH_WRITE : PH_READ;
        end
      end
      default: next_state = PH_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= PH_IDLE;
      addr_q <= 12'h000;
    end else begin
      state <= next_state;
      if (accept) begin
        addr_q <= haddr[11:0];
      end
    end
  end

  // each core owns its register, so cores never wait on one another
  genvar c;
  generate
    for (c = 0; c < `PD_CORES; c++) begin : g_core
      wire hit = wr_phase && in_core && core_idx == `PD_CORE_IDX_W'(c);
      assign core_wr[c] = '{
        dir_a: hit && reg_ofs == `PD_OFS_DIR_A,
        range_sel: hit && reg_ofs == `PD_OFS_RANGE_SEL,
        range_data: hit && reg_ofs == `PD_OFS_RANGE_DATA,
        bit_op: hit && reg_ofs == `PD_OFS_BIT,
        ctrl: hit && reg_ofs == `PD_OFS_CTRL,
        data: hwdata
      };
      core_direction_reg u_reg (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(core_wr[c]),
        .rd(core_rd[c])
      );
      assign core_dir[c] = core_rd[c].dir;
      assign core_en[c] = core_rd[c].en;
    end
  endgenerate

  // disabled cores are masked before the OR, their contents stay intact
  always_comb begin
    combined = 32'h0000_0000;
    for (int i = 0; i < `PD_CORES; i++) begin
      combined = combined | (core_dir[i] & {32{core_en[i]}});
    end
  end

  core_rd_s sel_rd;
  assign sel_rd = core_rd[core_idx];
  wire [31:0] core_read =
    (reg_ofs == `PD_OFS_DIR_A) ? sel_rd.dir :
    (reg_ofs == `PD_OFS_RANGE_SEL) ?
      {19'h0, sel_rd.range_y, 3'h0, sel_rd.range_x} :
    (reg_ofs == `PD_OFS_RANGE_DATA) ? sel_rd.range_val :
    (reg_ofs == `PD_OFS_CTRL) ? {31'h0, sel_rd.en} :
    32'h0000_0000; // second port and unused offsets read zero
  wire [31:0] read_val =
    in_core ? core_read :
    (addr_q == `PD_OFS_COMBINED) ? {pin_dir} :
    (addr_q == `PD_OFS_ACTIVE) ? {24'h0, core_active} :
    32'h0000_0000;

  // reads take one wait state so a write just before is seen in the core registers, but not yet in the combined or active words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      pin_dir <= `PD_DIR_RESET;
      core_active <= '0;
    end else begin
      hreadyout <= !(accept && !hwrite);
      hresp <= 1'b0;
      if (state == PH_READ) begin
        hrdata <= read_val;
      end
      pin_dir <= combined;
      core_active <= core_en;
    end
  end

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire core0_hit = in_core && core_idx == `PD_CORE_IDX_W'(0);
  wire [4:0] rx0 = core_rd[0].range_x;
  wire [4:0] ry0 = core_rd[0].range_y;
  wire [5:0] span0 = (rx0 >= ry0) ? 6'({1'b0, rx0} - {1'b0, ry0} + 6'h01)
                                  : 6'({1'b0, ry0} - {1'b0, rx0} + 6'h01);
  wire [31:0] bit_mask = 32'h0000_0001 << hwdata[4:0];

  a_whole_write: assert property (
    (wr_phase && core0_hit && reg_ofs == `PD_OFS_DIR_A)
    |=> core_dir[0] == $past(hwdata))
    else $error("whole register write not stored");

  a_bit_only: assert property (
    (wr_phase && core0_hit && reg_ofs == `PD_OFS_BIT && core_en[0])
    |=> ((core_dir[0] ^ $past(core_dir[0])) & ~$past(bit_mask)) == 32'h0
        && core_dir[0][$past(hwdata[4:0])] == $past(hwdata[`PD_BIT_VAL_POS]))
    else $error("bit write disturbed other bits");

  a_start_clears: assert property (
    (wr_phase && core0_hit && reg_ofs == `PD_OFS_CTRL && hwdata[0] && !core_en[0])
    |=> core_dir[0] == 32'h0 && core_en[0])
    else $error("core start did not clear directions");

  a_disabled_mask: assert property (
    (core_en == '0) |=> pin_dir == 32'h0)
    else $error("disabled cores drive a direction");

  a_or_merge: assert property (
    (core_en[0] && core_dir[0][31]) |=> pin_dir[31])
    else $error("active core output request lost");

  a_pin_follow: assert property (
    (wr_phase && core0_hit && reg_ofs == `PD_OFS_DIR_A && core_en[0])
    |=> ##1 (pin_dir & $past(hwdata, 2)) == $past(hwdata, 2))
    else $error("pins did not follow a write on the next clock");

  a_read_wait: assert property (
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");

  a_write_nowait: assert property (
    (accept && hwrite) |=> hreadyout && !hresp)
    else $error("write stalled or errored");

  a_range_aligned: assert property (
    (state == PH_DONE && core0_hit && reg_ofs == `PD_OFS_RANGE_DATA)
    |-> (hrdata >> span0) == 32'h0)
    else $error("range read not right-aligned");

  a_own_read: assert property (
    (state == PH_DONE && core0_hit && reg_ofs == `PD_OFS_DIR_A)
    |-> hrdata == core_dir[0])
    else $error("read returned other than own register");

  a_port_b_zero: assert property (
    (state == PH_DONE && in_core && reg_ofs == `PD_OFS_DIR_B) |-> hrdata == 32'h0)
    else $error("reserved register read nonzero");

  c_range_write: cover property (wr_phase && core0_hit && reg_ofs == `PD_OFS_RANGE_DATA);
  c_range_read: cover property (state == PH_DONE && reg_ofs == `PD_OFS_RANGE_DATA);
  c_core_start: cover property (!core_en[1] ##1 core_en[1]);
  c_two_cores: cover property (core_en[0] && core_en[1] && (core_dir[0] & core_dir[1]) != 0);
endmodule // pin_direction_combiner

// [common/pin_direction_params.svh]
// offsets, field positions, reset values and sizes of the pin direction block
`ifndef PIN_DIRECTION_PARAMS_SVH
`define PIN_DIRECTION_PARAMS_SVH
`define PD_CORES 8
`define PD_CORE_IDX_W 3
`define PD_PINS 32
`define PD_OFS_DIR_A 5'h00
`define PD_OFS_DIR_B 5'h04
`define PD_OFS_RANGE_SEL 5'h08
`define PD_OFS_RANGE_DATA 5'h0c
`define PD_OFS_BIT 5'h10
`define PD_OFS_CTRL 5'h14
`define PD_OFS_COMBINED 12'h100
`define PD_OFS_ACTIVE 12'h104
`define PD_CORE_AREA_MSB 11
`define PD_CORE_AREA_LSB 8
`define PD_DIR_RESET 32'h0000_0000
`define PD_RANGE_X_LSB 0
`define PD_RANGE_Y_LSB 8
`define PD_BIT_VAL_POS 8
`define PD_CTRL_EN_POS 0
`endif

// [common/pin_direction_pkg.sv]
// types shared by the pin direction combiner and its per-core register
package pin_direction_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10,
    PH_DONE = 2'b11
  } bus_phase_e;
  typedef struct packed {
    logic dir_a;
    logic range_sel;
    logic range_data;
    logic bit_op;
    logic ctrl;
    logic [31:0] data;
  } core_wr_s;
  typedef struct packed {
    logic [31:0] dir;
    logic [31:0] range_val;
    logic [4:0] range_x;
    logic [4:0] range_y;
    logic en;
  } core_rd_s;
endpackage

// [hdl/core_direction_reg.sv]
// one core's direction register with whole, single-bit and range access
`timescale 1ns/1ps
`include "pin_direction_params.svh"
module core_direction_reg import pin_direction_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire core_wr_s wr,
  output core_rd_s rd
);
  logic [31:0] dir;
  logic en;
  logic [4:0] rx;
  logic [4:0] ry;
  logic [31:0] next_dir;
  logic [31:0] put_val;

  function automatic logic [5:0] span_of(input logic [4:0] x, input logic [4:0] y);
    return (x >= y) ? ({1'b0, x} - {1'b0, y} + 6'h01) : ({1'b0, y} - {1'b0, x} + 6'h01);
  endfunction

  // value bit i lands at y, then walks toward x
  function automatic logic [4:0] pos_of(input logic [4:0] x, input logic [4:0] y,
                                        input logic [4:0] i);
    return (x >= y) ? 5'(y + i) : 5'(y - i);
  endfunction

  function automatic logic [31:0] range_put(input logic [31:0] cur, input logic [4:0] x,
                                            input logic [4:0] y, input logic [31:0] v);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < span_of(x, y)) begin
        r[pos_of(x, y, 5'(i))] = v[i];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] range_get(input logic [31:0] cur, input logic [4:0] x,
                                            input logic [4:0] y);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < span_of(x, y)) begin
        r[i] = cur[pos_of(x, y, 5'(i))];
      end
    end
    return r;
  endfunction

  wire start = wr.ctrl && wr.data[`PD_CTRL_EN_POS] && !en;
  wire [4:0] bit_idx = wr.data[4:0];

  always_comb begin
    put_val = dir;
    put_val[bit_idx] = wr.data[`PD_BIT_VAL_POS];
    next_dir = dir;
    if (start) begin
      next_dir = `PD_DIR_RESET;
    end else if (wr.dir_a) begin
      next_dir = wr.data;
    end else if (wr.bit_op) begin
      next_dir = put_val;
    end else if (wr.range_data) begin
      next_dir = range_put(dir, rx, ry, wr.data);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir <= `PD_DIR_RESET;
      en <= 1'b0;
      rx <= 5'h00;
      ry <= 5'h00;
    end else begin
      dir <= next_dir;
      if (wr.ctrl) begin
        en <= wr.data[`PD_CTRL_EN_POS];
      end
      if (wr.range_sel) begin
        rx <= wr.data[`PD_RANGE_X_LSB +: 5];
        ry <= wr.data[`PD_RANGE_Y_LSB +: 5];
      end
    end
  end

  // one driver for the whole struct so no field has a second source
  assign rd = '{
    dir: dir,
    range_val: range_get(dir, rx, ry),
    range_x: rx,
    range_y: ry,
    en: en
  };
endmodule // core_direction_reg

// [verification/pin_bank_model.sv]
// shared port pins seen from outside: pull-down where no core drives
`timescale 1ns/1ps
module pin_bank_model (
  input wire logic [31:0] pin_dir,
  input wire logic [31:0] drive_val,
  output logic [31:0] pin_level
);
  // an input pin floats to the pull-down, never the last driven value
  assign pin_level = pin_dir & drive_val;
endmodule // pin_bank_model

// [verification/pin_direction_combiner_tb.sv]
// self-checking bench for the pin direction combiner
`timescale 1ns/1ps
`include "pin_direction_params.svh"
module pin_direction_combiner_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp;
  logic [31:0] haddr, hwdata, hrdata, pin_dir, drv, lvl, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] hprot;
  logic [7:0] core_active, en_m;
  logic [31:0] dir_m [8];
  logic [31:0] exp_q [$];
  logic [4:0] i;
  int n_mismatch, checks_done;

  pin_direction_combiner dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(3'h0), .hprot(hprot),
    .hmastlock(1'b0), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_dir(pin_dir), .core_active(core_active));
  pin_bank_model pins (.pin_dir(pin_dir), .drive_val(drv), .pin_level(lvl));

  initial begin
    hclk = 0;
    forever #20 hclk = ~hclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function logic [31:0] comb();
    comb = 0;
    for (int c = 0; c < 8; c++) if (en_m[c]) comb |= dir_m[c];
  endfunction

  // one single word transfer; waits on hready at each phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hprot <= 4'($urandom);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wcore(input int c, input logic [31:0] ofs, input logic [31:0] wd);
    bus(1'b1, 32'(c * 32) + ofs, wd);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // pins settle two edges after the write data edge
  task pins_ok;
    repeat (2) @(posedge hclk);
    check(pin_dir, comb());
    check(lvl, comb() & drv);
    check({24'h0, core_active}, {24'h0, en_m});
  endtask

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
    end else begin
      if (rd_dp && hreadyout) check(hrdata, exp_q.pop_front());
      if (hreadyout) rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    complete_run;
  end

  initial begin
    void'($urandom(61286));
    hresetn = 0; hsel = 0; haddr = 0; hwrite = 0; htrans = 0;
    hsize = 3'h2; hprot = 0; hwdata = 0; drv = 0; en_m = 0;
    foreach (dir_m[c]) dir_m[c] = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(0, 0);
    rd(`PD_OFS_COMBINED, 0);
    rd(`PD_OFS_ACTIVE, 0);
    for (int c = 0; c < 2; c++) begin
      wcore(c, `PD_OFS_CTRL, 1);
      en_m[c] = 1'b1;
    end
    pins_ok();
    dir_m[0] = 32'h0000b0f3;
    dir_m[1] = $urandom;
    drv <= $urandom;
    wcore(0, `PD_OFS_DIR_A, dir_m[0]);
    wcore(1, `PD_OFS_DIR_A, dir_m[1]);
    rd(0, dir_m[0]);
    rd(32, dir_m[1]);
    rd(`PD_OFS_COMBINED, comb());
    pins_ok();
    for (int k = 0; k < 2; k++) begin
      dir_m[0] = k ? 32'h0 : 32'hffffffff;
      wcore(0, `PD_OFS_DIR_A, dir_m[0]);
      rd(0, dir_m[0]);
    end
    repeat (6) begin
      i = 5'($urandom);
      d[0] = 1'($urandom);
      dir_m[0][i] = d[0];
      wcore(0, `PD_OFS_BIT, {23'h0, d[0], 3'h0, i});
      rd(0, dir_m[0]);
    end
    rd(`PD_OFS_BIT, 0);
    pins_ok();
    wcore(0, `PD_OFS_DIR_A, 0);
    wcore(0, `PD_OFS_RANGE_SEL, {19'h0, 5'd3, 3'h0, 5'd5});
    wcore(0, `PD_OFS_RANGE_DATA, 32'hfffffff6);
    rd(0, 32'h30);
    wcore(0, `PD_OFS_RANGE_SEL, {19'h0, 5'd5, 3'h0, 5'd3});
    wcore(0, `PD_OFS_RANGE_DATA, 32'h6);
    rd(0, 32'h18);
    wcore(0, `PD_OFS_DIR_A, 32'h000000a5);
    wcore(0, `PD_OFS_RANGE_SEL, {19'h0, 5'd4, 3'h0, 5'd7});
    rd(`PD_OFS_RANGE_SEL, {19'h0, 5'd4, 3'h0, 5'd7});
    rd(`PD_OFS_RANGE_DATA, 32'ha);
    dir_m[0] = 32'h000000a5;
    wcore(1, `PD_OFS_CTRL, 0);
    en_m[1] = 1'b0;
    dir_m[2] = 32'hffff0000;
    wcore(2, `PD_OFS_DIR_A, dir_m[2]);
    rd(64, dir_m[2]);
    rd(`PD_OFS_COMBINED, comb());
    pins_ok();
    wcore(1, `PD_OFS_CTRL, 1);
    en_m[1] = 1'b1;
    dir_m[1] = 0;
    rd(32, 0);
    rd(32 + `PD_OFS_CTRL, 1);
    pins_ok();
    wcore(0, `PD_OFS_DIR_B, $urandom);
    rd(`PD_OFS_DIR_B, 0);
    bus(1'b1, 32'h200, $urandom);
    rd(32'h200, 0);
    repeat (2) @(posedge hclk);
    check(32'(exp_q.size()), 0);
    check({31'h0, hresp}, 0);
    complete_run;
  end
endmodule // pin_direction_combiner_tb
